// [rtl/fpc_ctl.sv]
/*
  CPU frequency program and recovery control with its management bus slave.
  Assumes scl and sda are synchronous to core_clk; the watchdog counter lives outside
  and reports a one-cycle timeout pulse.

*/
`timescale 1ns/10ps
module fpc_ctl #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [4:0] strap_ratio_code,
  input wire logic wd_timeout,
  output logic watchdog_run_enable,
  output logic wd_count_start,
  output logic freq_load,
  output fpc_pkg::fpc_freq_t freq_out
);
  import fpc_pkg::*;

  if (SLAVE_ADDR > 7'h77 || SLAVE_ADDR < 7'h08) begin : g_addr_check
    $error("SLAVE_ADDR falls in a reserved bus address range");
  end

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ACK_A = 4'b0010,
    ST_CMD = 4'b0011,
    ST_ACK_C = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_ACK_W = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_RACK = 4'b1000
  } fpc_bus_st_t;

  logic scl_rise, scl_fall, start_det, stop_det, sda_now;

  fpc_bus_edges u_edges (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det),
    .sda_now(sda_now)
  );

  // Bus engine state
  fpc_bus_st_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shreg_r, shreg_nxt;
  logic [7:0] idx_r, idx_nxt;
  logic sda_oe_r, sda_oe_nxt;
  logic nack_r, nack_nxt;
  logic wr_en;
  logic [7:0] rd_data;

  // Register state
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] rec_n_r, rec_n_nxt;
  logic [7:0] rec_sel_m_r, rec_sel_m_nxt;
  logic [7:0] syn_n_r, syn_n_nxt;
  logic [7:0] prog_syn_m_r, prog_syn_m_nxt;
  logic [7:0] rsvd_r, rsvd_nxt;
  logic [7:0] syn_n_act_r, syn_n_act_nxt;
  logic [4:0] strap_r, strap_nxt;
  logic strap_taken_r, strap_taken_nxt;
  logic rec_active_r, rec_active_nxt;
  logic load_r, load_nxt;
  logic wd_start_r, wd_start_nxt, sda_lvl_r;
  fpc_freq_t freq_r, freq_nxt;
  fpc_ctl_t ctl;

  always_comb begin
    unique case (idx_r)
      IDX_CTRL: rd_data = ctrl_r;
      IDX_REC_N: rd_data = rec_n_r;
      IDX_REC_SEL_M: rd_data = rec_sel_m_r;
      IDX_SYN_N: rd_data = syn_n_r;
      IDX_PROG_SYN_M: rd_data = prog_syn_m_r;
      IDX_RSVD_TAIL: rd_data = rsvd_r;
      IDX_STATUS: rd_data = {strap_r, freq_r.src};
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    shreg_nxt = shreg_r;
    idx_nxt = idx_r;
    sda_oe_nxt = sda_oe_r;
    nack_nxt = nack_r;
    wr_en = 1'b0;
    if (stop_det) begin
      st_nxt = ST_IDLE;
      sda_oe_nxt = 1'b0;
    end else if (start_det) begin
      // Repeated start re-enters address phase and keeps the index
      st_nxt = ST_ADDR;
      cnt_nxt = 4'h0;
      sda_oe_nxt = 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: sda_oe_nxt = 1'b0;
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            shreg_nxt = {shreg_r[6:0], sda_now};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
            cnt_nxt = 4'h0;
            if (st_r == ST_ADDR) begin
              sda_oe_nxt = (shreg_r[7:1] == SLAVE_ADDR);
              st_nxt = (shreg_r[7:1] == SLAVE_ADDR) ? ST_ACK_A : ST_IDLE;
            end else begin
              sda_oe_nxt = 1'b1;
              st_nxt = (st_r == ST_CMD) ? ST_ACK_C : ST_ACK_W;
              if (st_r == ST_CMD) begin
                idx_nxt = shreg_r;
              end
            end
          end
        end
        ST_ACK_A: begin
          if (scl_fall) begin
            if (shreg_r[0]) begin
              shreg_nxt = rd_data;
              sda_oe_nxt = ~rd_data[7];
              st_nxt = ST_RDATA;
            end else begin
              sda_oe_nxt = 1'b0;
              st_nxt = ST_CMD;
            end
          end
        end
        ST_ACK_C: begin
          if (scl_fall) begin
            sda_oe_nxt = 1'b0;
            st_nxt = ST_WDATA;
          end
        end
        ST_ACK_W: begin
          // Commit only once the acknowledge bit has been clocked out
          if (scl_fall) begin
            wr_en = 1'b1;
            idx_nxt = idx_r + 8'h01;
            sda_oe_nxt = 1'b0;
            st_nxt = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == BITS_PER_BYTE) begin
              sda_oe_nxt = 1'b0;
              cnt_nxt = 4'h0;
              st_nxt = ST_RACK;
            end else begin
              shreg_nxt = {shreg_r[6:0], 1'b0};
              sda_oe_nxt = ~shreg_r[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nack_nxt = sda_now;
          end else if (scl_fall) begin
            if (nack_r) begin
              st_nxt = ST_IDLE;
            end else begin
              idx_nxt = idx_r + 8'h01;
              shreg_nxt = rd_data;
              sda_oe_nxt = ~rd_data[7];
              st_nxt = ST_RDATA;
            end
          end
        end
        default: begin
          st_nxt = ST_IDLE;
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      shreg_r <= 8'h00;
      idx_r <= 8'h00;
      sda_oe_r <= 1'b0;
      nack_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      shreg_r <= shreg_nxt;
      idx_r <= idx_nxt;
      sda_oe_r <= sda_oe_nxt;
      nack_r <= nack_nxt;
    end
  end

  // Register file and frequency control
  always_comb begin
    ctrl_nxt = ctrl_r;
    rec_n_nxt = rec_n_r;
    rec_sel_m_nxt = rec_sel_m_r;
    syn_n_nxt = syn_n_r;
    prog_syn_m_nxt = prog_syn_m_r;
    rsvd_nxt = rsvd_r;
    syn_n_act_nxt = syn_n_act_r;
    rec_active_nxt = rec_active_r;
    load_nxt = 1'b0;
    // Strap level is caught on the first edge after reset release
    strap_nxt = strap_taken_r ? strap_r : strap_ratio_code;
    strap_taken_nxt = 1'b1;
    if (wr_en) begin
      unique case (idx_r)
        IDX_CTRL: begin
          ctrl_nxt[CTRL_WD_RUN_BIT:0] = shreg_r[CTRL_WD_RUN_BIT:0];
          if (shreg_r[CTRL_WD_STATUS_BIT]) begin
            ctrl_nxt[CTRL_WD_STATUS_BIT] = 1'b0;
          end
        end
        IDX_REC_N: begin
          rec_n_nxt = shreg_r;
          load_nxt = 1'b1;
        end
        IDX_REC_SEL_M: begin
          rec_sel_m_nxt = shreg_r;
          load_nxt = 1'b1;
        end
        IDX_SYN_N: syn_n_nxt = shreg_r;
        IDX_PROG_SYN_M: begin
          // N only becomes live together with M; leaving recovery needs this write
          prog_syn_m_nxt = shreg_r;
          syn_n_act_nxt = syn_n_r;
          rec_active_nxt = 1'b0;
          load_nxt = 1'b1;
        end
        IDX_RSVD_TAIL: rsvd_nxt = shreg_r;
        default: begin
        end
      endcase
    end
    // Timeout after the clear so a same-cycle event still marks the status
    if (wd_timeout) begin
      ctrl_nxt[CTRL_WD_STATUS_BIT] = 1'b1;
      rec_active_nxt = 1'b1;
      load_nxt = 1'b1;
    end
  end

  assign ctl = '{
    prog_en: prog_syn_m_r[PROG_EN_BIT],
    synth_n: syn_n_act_r,
    synth_m: prog_syn_m_r[6:0],
    rec_sel: rec_sel_m_r[REC_SEL_BIT],
    rec_n: rec_n_r,
    rec_m: rec_sel_m_r[6:0],
    override: ctrl_r[CTRL_OVERRIDE_BIT],
    sw_code: ctrl_r[4:0],
    strap_code: strap_r,
    rec_active: rec_active_r
  };

  fpc_freq_mux u_mux (
    .ctl(ctl),
    .freq(freq_nxt)
  );

  // Watchdog restarts on every freq_load pulse, but only while enabled
  assign wd_start_nxt = load_nxt & ctrl_nxt[CTRL_WD_RUN_BIT];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      rec_n_r <= REC_N_RST;
      rec_sel_m_r <= REC_SEL_M_RST;
      syn_n_r <= SYN_N_RST;
      prog_syn_m_r <= PROG_SYN_M_RST;
      rsvd_r <= RSVD_TAIL_RST;
      syn_n_act_r <= SYN_N_RST;
      strap_r <= 5'h00;
      strap_taken_r <= 1'b0;
      rec_active_r <= 1'b0;
      load_r <= 1'b0;
      wd_start_r <= 1'b0;
      sda_lvl_r <= 1'b0;
      freq_r <= '{src: FPC_SRC_STRAP, n: 8'h00, m: 7'h00, ratio: 5'h00};
    end else begin
      ctrl_r <= ctrl_nxt;
      rec_n_r <= rec_n_nxt;
      rec_sel_m_r <= rec_sel_m_nxt;
      syn_n_r <= syn_n_nxt;
      prog_syn_m_r <= prog_syn_m_nxt;
      rsvd_r <= rsvd_nxt;
      syn_n_act_r <= syn_n_act_nxt;
      strap_r <= strap_nxt;
      strap_taken_r <= strap_taken_nxt;
      rec_active_r <= rec_active_nxt;
      load_r <= load_nxt;
      wd_start_r <= wd_start_nxt;
      // Open drain: the pin value never leaves low, only the enable moves
      sda_lvl_r <= 1'b0;
      freq_r <= freq_nxt;
    end
  end

  assign sda_o = sda_lvl_r;
  assign sda_oe = sda_oe_r;
  assign watchdog_run_enable = ctrl_r[CTRL_WD_RUN_BIT];
  assign wd_count_start = wd_start_r;
  assign freq_load = load_r;
  assign freq_out = freq_r;

endmodule : fpc_ctl

// [rtl/fpc_pkg.sv]
/*
  Shared constants and types for the CPU frequency program and recovery control.
  Assumes a single 50 MHz core clock and byte-wide management registers.
*/
package fpc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;

  // Register indices, selected by the command byte of a bus write
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_REC_N = 8'h01;
  localparam logic [7:0] IDX_REC_SEL_M = 8'h02;
  localparam logic [7:0] IDX_SYN_N = 8'h03;
  localparam logic [7:0] IDX_PROG_SYN_M = 8'h04;
  localparam logic [7:0] IDX_RSVD_TAIL = 8'h05;
  localparam logic [7:0] IDX_STATUS = 8'h06;

  // Field positions
  localparam int unsigned CTRL_OVERRIDE_BIT = 5;
  localparam int unsigned CTRL_WD_RUN_BIT = 6;
  localparam int unsigned CTRL_WD_STATUS_BIT = 7;
  localparam int unsigned REC_SEL_BIT = 7;
  localparam int unsigned PROG_EN_BIT = 7;

  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] REC_N_RST = 8'h00;
  localparam logic [7:0] REC_SEL_M_RST = 8'h00;
  localparam logic [7:0] SYN_N_RST = 8'h00;
  localparam logic [7:0] PROG_SYN_M_RST = 8'h00;
  localparam logic [7:0] RSVD_TAIL_RST = 8'h03;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    FPC_SRC_STRAP = 3'b000,
    FPC_SRC_SW_CODE = 3'b001,
    FPC_SRC_SYNTH = 3'b010,
    FPC_SRC_REC_STRAP = 3'b011,
    FPC_SRC_REC_NM = 3'b100
  } fpc_src_t;

  typedef struct packed {
    logic prog_en;
    logic [7:0] synth_n;
    logic [6:0] synth_m;
    logic rec_sel;
    logic [7:0] rec_n;
    logic [6:0] rec_m;
    logic override;
    logic [4:0] sw_code;
    logic [4:0] strap_code;
    logic rec_active;
  } fpc_ctl_t;

  typedef struct packed {
    fpc_src_t src;
    logic [7:0] n;
    logic [6:0] m;
    logic [4:0] ratio;
  } fpc_freq_t;

endpackage : fpc_pkg

// [rtl/fpc_bus_edges.sv]
/*
  Edge and condition detector for the management bus clock and data lines.
  Assumes both lines are already synchronous to core_clk.
*/
`timescale 1ns/10ps
module fpc_bus_edges (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det,
  output logic sda_now
);
  import fpc_pkg::*;

  logic [1:0] scl_r, scl_nxt;
  logic [1:0] sda_r, sda_nxt;

  always_comb begin
    scl_nxt = {scl_r[0], scl_i};
    sda_nxt = {sda_r[0], sda_i};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_r <= 2'h3;
      sda_r <= 2'h3;
    end else begin
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
    end
  end

  assign scl_rise = scl_r[0] & ~scl_r[1];
  assign scl_fall = ~scl_r[0] & scl_r[1];
  // Data moving while the clock stays high marks a frame boundary
  assign start_det = scl_r[0] & scl_r[1] & sda_r[1] & ~sda_r[0];
  assign stop_det = scl_r[0] & scl_r[1] & ~sda_r[1] & sda_r[0];
  assign sda_now = sda_r[0];

endmodule : fpc_bus_edges

// [rtl/fpc_freq_mux.sv]
/*
  Chooses the CPU frequency source, divider pair and output ratio code.
  Assumes the caller registers the result before it leaves the block.
*/
`timescale 1ns/10ps
module fpc_freq_mux (
  input fpc_pkg::fpc_ctl_t ctl,
  output fpc_pkg::fpc_freq_t freq
);
  import fpc_pkg::*;

  logic [4:0] ratio;

  always_comb begin
    ratio = ctl.override ? ctl.sw_code : ctl.strap_code;
    freq.ratio = ratio;
    freq.n = 8'h00;
    freq.m = 7'h00;
    if (ctl.rec_active) begin
      // Recovery wins over program and override source choice until a write to IDX_PROG_SYN_M
      if (ctl.rec_sel) begin
        freq.src = FPC_SRC_REC_NM;
        freq.n = ctl.rec_n;
        freq.m = ctl.rec_m;
      end else begin
        freq.src = FPC_SRC_REC_STRAP;
        freq.ratio = ctl.strap_code;
      end
    end else if (ctl.prog_en) begin
      freq.src = FPC_SRC_SYNTH;
      freq.n = ctl.synth_n;
      freq.m = ctl.synth_m;
    end else begin
      freq.src = ctl.override ? FPC_SRC_SW_CODE : FPC_SRC_STRAP;
    end
  end

endmodule : fpc_freq_mux

// [sim/fpc_ctl_checker.sv]
/*
  Port-level assertions for the CPU frequency program and recovery control.
  Assumes strap inputs are held steady by the bench and a bus of 5+ cycles per phase.
*/
`timescale 1ns/10ps
module fpc_ctl_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [4:0] strap_ratio_code,
  input wire logic wd_timeout,
  input wire logic watchdog_run_enable,
  input wire logic wd_count_start,
  input wire logic freq_load,
  input fpc_pkg::fpc_freq_t freq_out
);
  import fpc_pkg::*;
  logic [2:0] age_r, age_nxt;
  // Age guard keeps the strap capture right after reset out of the strap ratio and divider change checks
  always_comb begin
    age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      age_r <= 3'h0;
    end else begin
      age_r <= age_nxt;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  timeout_recover_a: assert property (wd_timeout |=> freq_load ##1
    (freq_out.src inside {FPC_SRC_REC_STRAP, FPC_SRC_REC_NM})) else $error("no recovery");
  rec_strap_ratio_a: assert property (freq_out.src == FPC_SRC_REC_STRAP
    |-> freq_out.ratio == strap_ratio_code) else $error("recovery ratio not strap");
  strap_ratio_a: assert property (age_r == 3'h7 && freq_out.src == FPC_SRC_STRAP
    |-> freq_out.ratio == strap_ratio_code) else $error("strap ratio wrong");
  change_needs_load_a: assert property (age_r == 3'h7 && $changed({freq_out.n, freq_out.m})
    |-> freq_load || $past(freq_load)) else $error("divider change without load");
  wd_gate_a: assert property (wd_count_start == (freq_load && watchdog_run_enable))
    else $error("watchdog start wrong");
  // A bus-written load appears on the very edge at which the data ack is let go
  commit_after_ack_a: assert property (freq_load && !$past(wd_timeout)
    |-> $fell(sda_oe)) else $error("load not after ack");
  oe_low_phase_a: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda moved with scl high");
  open_drain_a: assert property (sda_o == 1'b0) else $error("sda driven high");
  reset_default_a: assert property ($rose(rst_n) |-> freq_out.src == FPC_SRC_STRAP
    && !watchdog_run_enable && !sda_oe && !freq_load ##2 freq_out.ratio == strap_ratio_code)
    else $error("reset defaults wrong");
endmodule : fpc_ctl_checker

bind fpc_ctl fpc_ctl_checker u_fpc_ctl_checker (.core_clk(core_clk), .rst_n(rst_n),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .strap_ratio_code(strap_ratio_code), .wd_timeout(wd_timeout),
  .watchdog_run_enable(watchdog_run_enable), .wd_count_start(wd_count_start),
  .freq_load(freq_load), .freq_out(freq_out));

// [sim/fpc_host.sv]
/*
  Management bus host model: drives scl and pulls sda low, never drives it high.
  Assumes a pull-up resolves sda outside and the device never stretches scl.
*/
`timescale 1ns/10ps
module fpc_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Five cycles a phase stays clear of the three-cycle minimum
  task automatic ph();
    repeat (5) @(posedge core_clk);
  endtask : ph
  task automatic start();
    sda_low <= 1'b0;
    ph();
    scl <= 1'b1;
    ph();
    sda_low <= 1'b1;
    ph();
    scl <= 1'b0;
    ph();
  endtask : start
  task automatic stop();
    sda_low <= 1'b1;
    ph();
    scl <= 1'b1;
    ph();
    sda_low <= 1'b0;
    ph();
  endtask : stop
  task automatic bit_io(input logic b, output logic s);
    sda_low <= !b;
    ph();
    scl <= 1'b1;
    ph();
    s = sda_line;
    scl <= 1'b0;
    ph();
  endtask : bit_io
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask : put_byte
  task automatic write_regs(input logic [6:0] a, input logic [7:0] idx, input int n,
                            input logic [15:0] d, output logic ok);
    logic k1, k2;
    start();
    put_byte({a, 1'b0}, k1);
    put_byte(idx, k2);
    ok = k1 & k2;
    for (int i = 0; i < n; i++) begin
      put_byte(d[8*i +: 8], k2);
      ok = ok & k2;
    end
    stop();
  endtask : write_regs
  // Stops four bits into a data byte, which must leave the register alone
  task automatic partial(input logic [7:0] idx);
    logic k;
    start();
    put_byte({DEV_ADDR, 1'b0}, k);
    put_byte(idx, k);
    repeat (4) bit_io(1'b0, k);
    stop();
  endtask : partial
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] d);
    logic k;
    start();
    put_byte({DEV_ADDR, 1'b0}, k);
    put_byte(idx, k);
    start();
    put_byte({DEV_ADDR, 1'b1}, k);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, k);
    stop();
  endtask : read_reg
endmodule : fpc_host

// [sim/cpu_freq_program_recovery_ctl_tb.sv]
/*
  Self-checking bench for the frequency control block through its management bus.
  Assumes the design package and the host model are compiled first.
*/
`timescale 1ns/10ps
module cpu_freq_program_recovery_ctl_tb;
  import fpc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wd_timeout = 1'b0;
  logic [4:0] strap_ratio_code = 5'h13;
  logic scl, host_low, sda_i, sda_o, sda_oe, run_en, wd_start, freq_load, ok;
  logic [7:0] rd;
  fpc_freq_t freq_out;
  int miscompares = 0, checked = 0, cycles = 0, loads = 0, starts = 0, l, s;
  always #10 core_clk = ~core_clk;
  assign sda_i = !(host_low || (sda_oe && !sda_o));
  fpc_ctl u_fpc_ctl (.core_clk(core_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .strap_ratio_code(strap_ratio_code),
    .wd_timeout(wd_timeout), .watchdog_run_enable(run_en), .wd_count_start(wd_start),
    .freq_load(freq_load), .freq_out(freq_out));
  fpc_host u_fpc_host (.core_clk(core_clk), .sda_line(sda_i), .scl(scl), .sda_low(host_low));
  task automatic finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (freq_load === 1'b1) loads <= loads + 1;
    if (wd_start === 1'b1) starts <= starts + 1;
    if (cycles == 60000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] idx, input int n, input logic [15:0] d);
    u_fpc_host.write_regs(7'h2a, idx, n, d, ok);
  endtask : wr
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    u_fpc_host.read_reg(idx, rd);
    check(rd, exp);
  endtask : rdchk
  task automatic fo(input fpc_src_t src, input logic [4:0] r);
    check({freq_out.src, freq_out.ratio}, {src, r});
  endtask : fo
  task automatic pulse();
    wd_timeout <= 1'b1;
    @(posedge core_clk);
    wd_timeout <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : pulse
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    fo(FPC_SRC_STRAP, 5'h13);
    check(run_en, 1'b0);
    for (int i = 0; i < 6; i++) begin
      rdchk(8'(i), (i == 5) ? 8'h03 : 8'h00);
    end
    rdchk(IDX_STATUS, 8'h98);
    $display("test reset done");
    wr(IDX_CTRL, 1, 16'h000a);
    check(ok, 1'b1);
    fo(FPC_SRC_STRAP, 5'h13);
    wr(IDX_CTRL, 1, 16'h002a);
    fo(FPC_SRC_SW_CODE, 5'h0a);
    $display("test override done");
    l = loads;
    wr(IDX_SYN_N, 1, 16'h0064);
    check(loads - l, 0);
    fo(FPC_SRC_SW_CODE, 5'h0a);
    wr(IDX_PROG_SYN_M, 1, 16'h0098);
    check(loads - l, 1);
    check(freq_out, {FPC_SRC_SYNTH, 8'h64, 7'h18, 5'h0a});
    rdchk(IDX_PROG_SYN_M, 8'h98);
    $display("test program done");
    wr(IDX_CTRL, 1, 16'h006a);
    check(run_en, 1'b1);
    l = loads;
    s = starts;
    wr(IDX_REC_N, 2, 16'ha15a);
    check(loads - l, 2);
    check(starts - s, 2);
    pulse();
    check({freq_out.src, freq_out.n, freq_out.m}, {FPC_SRC_REC_NM, 8'h5a, 7'h21});
    rdchk(IDX_CTRL, 8'hea);
    wr(IDX_CTRL, 1, 16'h00ea);
    rdchk(IDX_CTRL, 8'h6a);
    wr(IDX_REC_SEL_M, 1, 16'h0021);
    pulse();
    fo(FPC_SRC_REC_STRAP, 5'h13);
    wr(IDX_PROG_SYN_M, 1, 16'h0018);
    fo(FPC_SRC_SW_CODE, 5'h0a);
    $display("test recovery done");
    u_fpc_host.write_regs(7'h2b, IDX_RSVD_TAIL, 1, 16'h0000, ok);
    check(ok, 1'b0);
    u_fpc_host.partial(IDX_RSVD_TAIL);
    rdchk(IDX_RSVD_TAIL, 8'h03);
    wr(8'h07, 1, 16'h0055);
    rdchk(8'h07, 8'h00);
    wr(IDX_STATUS, 1, 16'h0000);
    rdchk(IDX_STATUS, 8'h99);
    wr(IDX_RSVD_TAIL, 1, 16'h00f3);
    rdchk(IDX_RSVD_TAIL, 8'hf3);
    $display("test refusal done");
    wr(IDX_CTRL, 1, 16'h002a);
    l = loads;
    s = starts;
    wr(IDX_REC_N, 1, 16'h0033);
    check(loads - l, 1);
    check(starts - s, 0);
    $display("test watchdog off done");
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdchk(IDX_PROG_SYN_M, 8'h00);
    rdchk(IDX_RSVD_TAIL, 8'h03);
    fo(FPC_SRC_STRAP, 5'h13);
    $display("test second reset done");
    finish_test();
  end
endmodule : cpu_freq_program_recovery_ctl_tb
